// ---- design/fmcf_pkg.sv ----
// Package for the framer mode configuration block: offsets, fields, timing.
// Assumes an APB slave with 32-bit data and one aligned word per register.
package fmcf_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_MODE     = 8'h00;
  localparam logic [7:0] ADDR_SYSCFG   = 8'h04;
  localparam logic [7:0] ADDR_DISABLE  = 8'h08;
  localparam logic [7:0] ADDR_STATUS   = 8'h0c;
  localparam logic [7:0] ADDR_MASK     = 8'h10;
  localparam logic [7:0] ADDR_LATCH_FE = 8'h14;
  localparam logic [7:0] ADDR_LATCH_CE = 8'h18;
  localparam logic [7:0] ADDR_LATCH_CV = 8'h1c;
  localparam logic [7:0] ADDR_LATCH_EB = 8'h20;
  localparam logic [7:0] ADDR_INFO     = 8'h24;

  // Field positions in framer_mode_one
  localparam int BIT_SEND_AIS  = 0;
  localparam int BIT_RATE_LOW  = 1;
  localparam int BIT_CNT_MODE  = 2;
  localparam int BIT_CRC_EN    = 3;
  localparam int BIT_LINE_STD  = 4;

  // Field positions in the system config word
  localparam int BIT_RATE_HIGH = 0;
  localparam int BIT_RATE_FAM  = 1;
  localparam int BIT_JAPAN     = 2;
  localparam int BIT_LOCAL_LP  = 3;
  localparam int BIT_ESF       = 4;

  // Status bits
  localparam int ST_SECOND  = 0;
  localparam int ST_SETTLED = 1;

  localparam logic [7:0] MODE_RESET   = 8'h00;
  localparam logic [7:0] SYSCFG_RESET = 8'h00;

  // Timing
  localparam int CLK_MHZ       = 100;
  localparam int SETTLE_US     = 20;
  localparam int SETTLE_CYCLES = SETTLE_US * CLK_MHZ;
  localparam int SECOND_S      = 1;
  localparam int SECOND_CYCLES = SECOND_S * CLK_MHZ * 1000000;

  typedef enum logic [2:0] {
    FMCF_RATE_2M048, FMCF_RATE_4M096, FMCF_RATE_8M192, FMCF_RATE_16M384,
    FMCF_RATE_1M544, FMCF_RATE_3M088, FMCF_RATE_6M176, FMCF_RATE_12M352
  } fmcf_rate_t;

  // Per-channel error events from the receive framer
  typedef struct packed {
    logic framing;
    logic checksum;
    logic code_viol;
    logic ebit;
  } fmcf_err_t;

  // Decoded mode towards the datapath
  typedef struct packed {
    logic       t1_mode;
    logic       japan;
    logic       crc6_check;
    logic       crc6_gen;
    logic       crc_bits_ones;
    fmcf_rate_t rate;
  } fmcf_mode_t;

endpackage : fmcf_pkg

// ---- design/fmcf_top.sv ----
// Framer mode configuration registers with error counters and AIS control.
// Assumes an APB master on pclk; line data arrives in the pclk domain.
//
// Decided for this implementation: the APB slave port and the placing of the registers.

module fmcf_top #(
  parameter int CNT_W         = 16,
  parameter int SETTLE_CYCLES = fmcf_pkg::SETTLE_CYCLES,
  parameter int SECOND_CYCLES = fmcf_pkg::SECOND_CYCLES
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire fmcf_pkg::fmcf_err_t err_event,
  input  wire logic                tx_data_a,
  input  wire logic                tx_data_b,
  output logic                     line_out_a,
  output logic                     line_out_b,
  output logic                     loop_data_a,
  output logic                     loop_data_b,
  output fmcf_pkg::fmcf_mode_t     mode_out,
  output logic                     mode_settled,
  output logic                     irq
);

  logic [7:0]       framer_mode_one;
  logic [7:0]       sys_cfg;
  logic [3:0]       counter_disable_register;
  logic [3:0]       disable_q;
  logic [1:0]       status;
  logic [1:0]       mask;
  // Four counters, one per error kind: framing, checksum, code, E-bit
  logic [CNT_W-1:0] cnt [4];
  logic [CNT_W-1:0] latched [4];
  logic [31:0]      settle_cnt;
  logic [31:0]      sec_cnt;
  logic             sec_tick;
  logic             settle_done_ev;
  logic             line_std_q;
  logic [31:0]      next_prdata;
  logic             next_pslverr;

  // Pready low at the take edge keeps a held request from being taken twice
  wire access   = psel && penable && !pready;
  wire wr       = access && pwrite;
  wire rd       = access && !pwrite;
  // Event bits in counter order, framing error at bit 0
  wire [3:0] ev = {err_event.ebit, err_event.code_viol,
                   err_event.checksum, err_event.framing};
  // Per-field views of the two configuration words
  wire line_standard_select = framer_mode_one[fmcf_pkg::BIT_LINE_STD];
  wire counter_mode_select  = framer_mode_one[fmcf_pkg::BIT_CNT_MODE];
  wire send_alarm_indication = framer_mode_one[fmcf_pkg::BIT_SEND_AIS];
  wire highway_rate_low     = framer_mode_one[fmcf_pkg::BIT_RATE_LOW];
  wire highway_rate_high    = sys_cfg[fmcf_pkg::BIT_RATE_HIGH];
  wire highway_rate_family  = sys_cfg[fmcf_pkg::BIT_RATE_FAM];
  wire crc_active = framer_mode_one[fmcf_pkg::BIT_CRC_EN]
                    && sys_cfg[fmcf_pkg::BIT_ESF];

  function automatic logic [31:0] widen(input logic [CNT_W-1:0] v);
    widen = 32'(v);
  endfunction

  // Saturating step: a stuck error source must not wrap the count to zero
  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
    sat_inc = (v == '1) ? v : v + CNT_W'(1);
  endfunction

  // Frozen mode reads the running count, second mode the latched one
  function automatic logic [31:0] counter_view(input int idx);
    counter_view = widen(counter_mode_select ? latched[idx] : cnt[idx]);
  endfunction

  // APB: one wait state so every answer comes from a flip-flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= access;
    end
  end

  always_comb begin
    next_prdata  = 32'h0000_0000;
    next_pslverr = 1'b0;
    unique case (paddr)
      fmcf_pkg::ADDR_MODE:     next_prdata = {24'h00_0000, framer_mode_one};
      fmcf_pkg::ADDR_SYSCFG:   next_prdata = {24'h00_0000, sys_cfg};
      fmcf_pkg::ADDR_DISABLE:
        next_prdata = {28'h000_0000, counter_disable_register};
      fmcf_pkg::ADDR_STATUS:   next_prdata = {30'h0, status};
      fmcf_pkg::ADDR_MASK:     next_prdata = {30'h0, mask};
      fmcf_pkg::ADDR_LATCH_FE: next_prdata = counter_view(0);
      fmcf_pkg::ADDR_LATCH_CE: next_prdata = counter_view(1);
      fmcf_pkg::ADDR_LATCH_CV: next_prdata = counter_view(2);
      fmcf_pkg::ADDR_LATCH_EB: next_prdata = counter_view(3);
      fmcf_pkg::ADDR_INFO:     next_prdata = {28'h000_0000, mode_out.rate,
                                 mode_settled};
      default:                 next_pslverr = 1'b1;
    endcase
  end

  // Read data holds after the access, so a late look still sees it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (access) begin
      prdata <= pwrite ? 32'h0000_0000 : next_prdata;
    end
  end

  // Error reply stands only beside pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= access && next_pslverr;
    end
  end

  // Writable configuration; unmapped writes are dropped, spare bits of
  // the mode word read back as written
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      framer_mode_one          <= fmcf_pkg::MODE_RESET;
      sys_cfg                  <= fmcf_pkg::SYSCFG_RESET;
      counter_disable_register <= 4'h0;
      mask                     <= 2'h0;
    end else if (wr) begin
      unique case (paddr)
        fmcf_pkg::ADDR_MODE:    framer_mode_one <= pwdata[7:0];
        fmcf_pkg::ADDR_SYSCFG:  sys_cfg <= pwdata[7:0];
        fmcf_pkg::ADDR_DISABLE: counter_disable_register <= pwdata[3:0];
        fmcf_pkg::ADDR_MASK:    mask <= pwdata[1:0];
        default: ;
      endcase
    end
  end

  // Settling timer after a line standard change
  // Restarts on every toggle, so a quick flip back still waits in full
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_std_q     <= 1'b0;
      settle_cnt     <= 32'h0000_0000;
      mode_settled   <= 1'b1;
      settle_done_ev <= 1'b0;
    end else begin
      line_std_q     <= line_standard_select;
      settle_done_ev <= 1'b0;
      if (line_std_q != line_standard_select) begin
        settle_cnt   <= 32'(SETTLE_CYCLES - 1);
        mode_settled <= 1'b0;
      end else if (!mode_settled) begin
        if (settle_cnt == 32'h0000_0000) begin
          mode_settled   <= 1'b1;
          settle_done_ev <= 1'b1;
        end else begin
          settle_cnt <= settle_cnt - 32'h0000_0001;
        end
      end
    end
  end

  // One-second divider, runs only in second mode
  // Held at zero in frozen mode so the first second after a switch is whole
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_cnt  <= 32'h0000_0000;
      sec_tick <= 1'b0;
    end else begin
      sec_tick <= 1'b0;
      if (!counter_mode_select) begin
        sec_cnt <= 32'h0000_0000;
      end else if (sec_cnt == 32'(SECOND_CYCLES - 1)) begin
        sec_cnt  <= 32'h0000_0000;
        sec_tick <= 1'b1;
      end else begin
        sec_cnt <= sec_cnt + 32'h0000_0001;
      end
    end
  end

  // Previous disable bits, the reference for the clear-on-set edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disable_q <= 4'h0;
    end else begin
      disable_q <= counter_disable_register;
    end
  end

  // Error counters, all governed by one mode bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 4; i++) begin
        cnt[i]     <= '0;
        latched[i] <= '0;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (!counter_mode_select) begin
          // Setting a disable bit clears the count to zero, and it holds there while the bit stays set
          if (counter_disable_register[i] && !disable_q[i]) begin
            cnt[i] <= '0;
          end else if (ev[i] && !counter_disable_register[i]) begin
            cnt[i] <= sat_inc(cnt[i]);
          end
        end else if (sec_tick) begin
          // An event in the latch cycle opens the new second
          latched[i] <= cnt[i];
          cnt[i]     <= ev[i] ? CNT_W'(1) : '0;
        end else if (ev[i]) begin
          cnt[i] <= sat_inc(cnt[i]);
        end
      end
    end
  end

  // Sticky status, cleared by reading; a new event wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= 2'h0;
    end else begin
      // Bit 0 marks the second tick, bit 1 the end of settling
      for (int i = 0; i < 2; i++) begin
        if ((i == fmcf_pkg::ST_SECOND ? sec_tick : settle_done_ev)) begin
          status[i] <= 1'b1;
        end else if (rd && paddr == fmcf_pkg::ADDR_STATUS) begin
          status[i] <= 1'b0;
        end
      end
    end
  end

  // Interrupt lags status by one cycle so that it leaves a flip-flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & mask);
    end
  end

  // Decoded mode towards the datapath
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_out <= '0;
    end else begin
      // J1 only matters in T1 operation
      mode_out.t1_mode       <= line_standard_select;
      mode_out.japan         <= line_standard_select
                                && sys_cfg[fmcf_pkg::BIT_JAPAN];
      // CRC bit positions go out as ones whenever CRC6 is off
      mode_out.crc6_check    <= crc_active;
      mode_out.crc6_gen      <= crc_active;
      mode_out.crc_bits_ones <= !crc_active;
      mode_out.rate <= fmcf_pkg::fmcf_rate_t'({highway_rate_family,
                         highway_rate_high, highway_rate_low});
    end
  end

  // Line outputs and the local loop tap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_out_a  <= 1'b0;
      line_out_b  <= 1'b0;
      loop_data_a <= 1'b0;
      loop_data_b <= 1'b0;
    end else begin
      // Both line outputs carry the alarm, never just one
      line_out_a <= send_alarm_indication | tx_data_a;
      line_out_b <= send_alarm_indication | tx_data_b;
      // Loop taps data before the AIS override
      loop_data_a <= sys_cfg[fmcf_pkg::BIT_LOCAL_LP] & tx_data_a;
      loop_data_b <= sys_cfg[fmcf_pkg::BIT_LOCAL_LP] & tx_data_b;
    end
  end

endmodule // fmcf_top

// ---- tb/fmcf_line_peer.sv ----
// Remote line side: transmit data pattern and receive error events.
// Assumes the bench calls pulse() from its main sequence.
module fmcf_line_peer (
  input  wire logic          pclk,
  output fmcf_pkg::fmcf_err_t err_event,
  output logic               tx_data_a,
  output logic               tx_data_b
);
  timeunit 1ns;
  timeprecision 1ps;
  // Changing pattern, so a stuck line output cannot pass
  logic [2:0] lfsr = 3'h5;
  assign tx_data_a = lfsr[0];
  assign tx_data_b = lfsr[2];
  always @(posedge pclk) lfsr <= {lfsr[1:0], lfsr[2] ^ lfsr[1]};
  initial err_event = '0;
  task automatic pulse(input fmcf_pkg::fmcf_err_t k, input int n);
    repeat (n) begin
      @(posedge pclk);
      err_event <= k;
      @(posedge pclk);
      err_event <= '0;
    end
  endtask
endmodule // fmcf_line_peer

// ---- tb/fmcf_top_assertions.sv ----
// Checker for fmcf_top: bus replies, mode decode and line outputs.
// Assumes it is bound into fmcf_top and sees only its ports.
module fmcf_top_assertions #(
  parameter int SETTLE_CYCLES = fmcf_pkg::SETTLE_CYCLES
) (
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [7:0]           paddr,
  input wire logic [31:0]          pwdata,
  input wire logic [31:0]          prdata,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire logic                 tx_data_a,
  input wire logic                 line_out_a,
  input wire logic                 loop_data_a,
  input wire fmcf_pkg::fmcf_mode_t mode_out,
  input wire logic                 mode_settled,
  input wire logic                 irq
);
  logic [31:0] low_run;
  logic [7:0] mode;
  logic [7:0] sys;
  logic [1:0] quiet;
  logic       bad;
  assign bad = paddr > fmcf_pkg::ADDR_INFO || paddr[1:0] != 2'b00;
  // Quiet gives the design two edges after a write, so either edge of
  // the register update is accepted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode <= '0;
      sys <= '0;
      quiet <= '0;
    end else if (psel && penable && !pready && pwrite
                 && paddr <= fmcf_pkg::ADDR_SYSCFG && !bad) begin
      if (paddr == fmcf_pkg::ADDR_MODE) mode <= pwdata[7:0];
      else sys <= pwdata[7:0];
      quiet <= '0;
    end else if (quiet != 2'd3) begin
      quiet <= quiet + 2'd1;
    end
  end
  // Length of the current low stretch of the settled flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_run <= '0;
    end else if (mode_settled) begin
      low_run <= '0;
    end else begin
      low_run <= low_run + 32'h0000_0001;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ais_ones: assert property (
    quiet >= 2 && mode[fmcf_pkg::BIT_SEND_AIS] |-> line_out_a)
    else $error("line output not all ones under AIS");
  a_ais_pass: assert property (
    quiet >= 2 && !mode[fmcf_pkg::BIT_SEND_AIS]
    |-> line_out_a == $past(tx_data_a))
    else $error("line output differs from transmit data");
  a_loop_clean: assert property (
    quiet >= 2 && sys[fmcf_pkg::BIT_LOCAL_LP]
    |-> loop_data_a == $past(tx_data_a))
    else $error("loop data altered");
  a_std_sel: assert property (
    quiet >= 2 |-> mode_out.t1_mode == mode[fmcf_pkg::BIT_LINE_STD])
    else $error("line standard decode wrong");
  a_crc_ignored: assert property (
    quiet >= 2 && !sys[fmcf_pkg::BIT_ESF]
    |-> !mode_out.crc6_check && !mode_out.crc6_gen)
    else $error("CRC6 active outside ESF");
  a_crc_enable: assert property (
    quiet >= 2 && sys[fmcf_pkg::BIT_ESF]
    |-> mode_out.crc6_gen == mode[fmcf_pkg::BIT_CRC_EN]
    && mode_out.crc_bits_ones == !mode[fmcf_pkg::BIT_CRC_EN])
    else $error("CRC6 enable decode wrong");
  a_rate_sel: assert property (
    quiet >= 2 |-> mode_out.rate == {sys[fmcf_pkg::BIT_RATE_FAM],
    sys[fmcf_pkg::BIT_RATE_HIGH], mode[fmcf_pkg::BIT_RATE_LOW]})
    else $error("highway rate decode wrong");
  a_settle_len: assert property (
    $rose(mode_settled) |-> low_run == 32'(SETTLE_CYCLES))
    else $error("settle time wrong");
  a_err_reply: assert property (psel && penable && pready
    |-> pslverr == bad && (pwrite || !bad || prdata == 32'h0))
    else $error("bus error reply wrong");
  c_ais_loop: cover property (quiet == 3 && mode[0] && sys[3]);
  c_irq: cover property ($rose(irq));
  c_slverr: cover property (pslverr);
endmodule // fmcf_top_assertions

bind fmcf_top fmcf_top_assertions #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .tx_data_a(tx_data_a),
  .line_out_a(line_out_a), .loop_data_a(loop_data_a),
  .mode_out(mode_out), .mode_settled(mode_settled), .irq(irq));

// ---- tb/fmcf_top_bench.sv ----
// Bench for fmcf_top: register, counter, interrupt and line tests.
// Assumes short settle and second counts and the line peer model.
module fmcf_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 pclk = 1'b0;
  logic                 presetn = 1'b0;
  logic                 psel = 1'b0;
  logic                 penable = 1'b0;
  logic                 pwrite = 1'b0;
  logic [7:0]           paddr = 8'h00;
  logic [31:0]          pwdata = 32'h0;
  logic [31:0]          prdata, rd;
  logic                 pready, pslverr, err, irq, settled;
  logic                 tx_a, tx_b, lo_a, lo_b, lp_a, lp_b, t_a, t_b;
  fmcf_pkg::fmcf_err_t  err_event;
  fmcf_pkg::fmcf_mode_t mode_out;
  int                   fail_count = 0;
  int                   n_tests = 0;
  int                   n;
  fmcf_top #(.SETTLE_CYCLES(20), .SECOND_CYCLES(50)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .err_event(err_event),
    .tx_data_a(tx_a), .tx_data_b(tx_b), .line_out_a(lo_a),
    .line_out_b(lo_b), .loop_data_a(lp_a), .loop_data_b(lp_b),
    .mode_out(mode_out), .mode_settled(settled), .irq(irq));
  fmcf_line_peer u_peer (.pclk(pclk), .err_event(err_event),
    .tx_data_a(tx_a), .tx_data_b(tx_b));
  initial forever #5 pclk = ~pclk;
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Waits as long as the slave needs; the watchdog bounds a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rc(input string nm, input logic [7:0] a,
                    input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge pclk);
  endtask
  // Registered flags lag a clearing access, hence the lead-in cycles
  task automatic wait_hi(input bit on_irq, input string nm);
    tick(2);
    n = 0;
    while ((on_irq ? irq : settled) !== 1'b1 && n < 300) begin
      @(posedge pclk);
      n++;
    end
    chk(nm, 1, on_irq ? irq : settled);
  endtask
  initial begin
    tick(10);
    presetn <= 1'b1;
    rc("mode", fmcf_pkg::ADDR_MODE, {24'h0, fmcf_pkg::MODE_RESET});
    rc("syscfg", fmcf_pkg::ADDR_SYSCFG, {24'h0, fmcf_pkg::SYSCFG_RESET});
    apb(1'b0, 8'h40, 32'h0);
    chk("slverr", 1, err);
    chk("bad read", 0, rd);
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, fmcf_pkg::ADDR_MODE, (i & 1) << fmcf_pkg::BIT_RATE_LOW);
      apb(1'b1, fmcf_pkg::ADDR_SYSCFG, i >> 1);
      tick(3);
      chk("rate", i, mode_out.rate);
    end
    rc("info", fmcf_pkg::ADDR_INFO, 32'h0000_000f);
    apb(1'b1, fmcf_pkg::ADDR_SYSCFG, 1 << fmcf_pkg::BIT_JAPAN);
    apb(1'b1, fmcf_pkg::ADDR_MODE, 1 << fmcf_pkg::BIT_LINE_STD);
    tick(3);
    chk("settling", 0, settled);
    chk("t1", 1, mode_out.t1_mode);
    chk("japan", 1, mode_out.japan);
    wait_hi(1'b0, "settled");
    apb(1'b1, fmcf_pkg::ADDR_MODE, 0);
    tick(3);
    chk("e1", 0, mode_out.t1_mode);
    wait_hi(1'b0, "settled");
    for (int j = 0; j < 4; j++) begin
      apb(1'b1, fmcf_pkg::ADDR_SYSCFG, (j >> 1) << fmcf_pkg::BIT_ESF);
      apb(1'b1, fmcf_pkg::ADDR_MODE, (j & 1) << fmcf_pkg::BIT_CRC_EN);
      tick(3);
      chk("crc check", j == 3, mode_out.crc6_check);
      chk("crc gen", j == 3, mode_out.crc6_gen);
      if (j >= 2) chk("crc ones", j == 2, mode_out.crc_bits_ones);
    end
    apb(1'b1, fmcf_pkg::ADDR_SYSCFG, 1 << fmcf_pkg::BIT_LOCAL_LP);
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, fmcf_pkg::ADDR_MODE, m << fmcf_pkg::BIT_SEND_AIS);
      tick(3);
      repeat (4) begin
        @(posedge pclk);
        t_a = tx_a;
        t_b = tx_b;
        @(negedge pclk);
        chk("out a", m ? 1'b1 : t_a, lo_a);
        chk("out b", m ? 1'b1 : t_b, lo_b);
        chk("loop a", t_a, lp_a);
        chk("loop b", t_b, lp_b);
      end
    end
    apb(1'b1, fmcf_pkg::ADDR_MODE, 0);
    u_peer.pulse(4'hf, 3);
    tick(2);
    for (int k = 0; k < 4; k++)
      rc("count", 8'(fmcf_pkg::ADDR_LATCH_FE + 4 * k), 3);
    apb(1'b1, fmcf_pkg::ADDR_DISABLE, 32'hf);
    u_peer.pulse(4'hf, 2);
    for (int k = 0; k < 4; k++)
      rc("cleared", 8'(fmcf_pkg::ADDR_LATCH_FE + 4 * k), 0);
    apb(1'b1, fmcf_pkg::ADDR_DISABLE, 0);
    apb(1'b1, fmcf_pkg::ADDR_MODE, 1 << fmcf_pkg::BIT_CNT_MODE);
    apb(1'b1, fmcf_pkg::ADDR_MASK, 1 << fmcf_pkg::ST_SECOND);
    apb(1'b0, fmcf_pkg::ADDR_STATUS, 0);
    wait_hi(1'b1, "irq");
    rc("status", fmcf_pkg::ADDR_STATUS, 1 << fmcf_pkg::ST_SECOND);
    tick(2);
    chk("irq clear", 0, irq);
    u_peer.pulse(4'h8, 4);
    wait_hi(1'b1, "irq");
    rc("latched", fmcf_pkg::ADDR_LATCH_FE, 4);
    rc("other", fmcf_pkg::ADDR_LATCH_CE, 0);
    apb(1'b0, fmcf_pkg::ADDR_STATUS, 0);
    wait_hi(1'b1, "irq");
    rc("relatched", fmcf_pkg::ADDR_LATCH_FE, 0);
    apb(1'b1, fmcf_pkg::ADDR_MASK, 0);
    tick(60);
    chk("masked", 0, irq);
    stop_test;
  end
  initial begin
    tick(20000);
    fail_count++;
    stop_test;
  end
endmodule // fmcf_top_bench
